// *** hdl/rx_desc_consts.svh ***
`ifndef RX_DESC_CONSTS_SVH
`define RX_DESC_CONSTS_SVH
// Function
// - ring wrap flag returns to list base
// - chain flag: second pointer is next descriptor
// - wrap beats chain when both set
// - second size bits 21:11, zero skips buffer
// - chain set without wrap ignores second size field
// - first size bits 10:0, zero uses second
// - host sizes are multiples of four
// - first pointer word three, longword aligned
// - second pointer word four, longword aligned
// - host descriptors longword aligned
// - overflow: runt and collision reported zero
// - watchdog timeout: runt reported zero
// - late collision: runt zero, rest valid
// - runt under 14 bytes: type, filter meaningless
// - watchdog flag set, length invalid
// - phy error forces crc error flag
`define RING_WRAP_BIT     25
`define CHAIN_NEXT_BIT    24
`define SECOND_BYTES_HI   21
`define SECOND_BYTES_LO   11
`define FIRST_BYTES_HI    10
`define FIRST_BYTES_LO    0
`define DESC_STRIDE       32'h0000_0010
`define ST_OVERRUN_BIT    0
`define ST_CRC_BIT        1
`define ST_DRIBBLE_BIT    2
`define ST_PHY_FAULT_BIT  3
`define ST_WATCHDOG_BIT   4
`define ST_FRAME_TYPE_BIT 5
`define ST_COLLISION_BIT  6
`define ST_RUNT_BIT       11
`define ST_LEN_LO         16
`define ST_LEN_HI         29
`define ST_FILTER_BIT     30
`define RUNT_TYPE_BYTES   14
`endif

// *** hdl/rx_desc_pkg.sv ***
package rx_desc_pkg;
	typedef enum logic [2:0] {
		WALK_IDLE   = 3'b000,
		WALK_FETCH  = 3'b001,
		WALK_FIRST  = 3'b010,
		WALK_SECOND = 3'b011,
		WALK_STATUS = 3'b100
	} walk_state_t;
endpackage : rx_desc_pkg

// *** hdl/rx_desc_if.sv ***
`timescale 1ns/1ps
interface rx_desc_if;
	logic        fetch_req;
	logic [31:0] fetch_addr;
	logic        fetch_ack;
	logic [31:0] control_word;
	logic [31:0] first_pointer;
	logic [31:0] second_pointer;
	logic        buf_valid;
	logic [31:0] buf_addr;
	logic [10:0] buf_bytes;
	logic        status_valid;
	logic [31:0] status_word;
	modport device (output fetch_req, fetch_addr, buf_valid, buf_addr, buf_bytes,
		status_valid, status_word,
		input fetch_ack, control_word, first_pointer, second_pointer);
	modport host (input fetch_req, fetch_addr, buf_valid, buf_addr, buf_bytes,
		status_valid, status_word,
		output fetch_ack, control_word, first_pointer, second_pointer);
endinterface : rx_desc_if

// *** hdl/rx_descriptor_walker.sv ***
`timescale 1ns/1ps
`include "rx_desc_consts.svh"
module rx_descriptor_walker
	import rx_desc_pkg::*;
(
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// list control
	input  wire logic        start,
	input  wire logic [31:0] list_base,
	// frame completion from receive engine
	input  wire logic        frame_done,
	input  wire logic [13:0] frame_len,
	input  wire logic        ev_overrun,
	input  wire logic        ev_watchdog,
	input  wire logic        ev_collision,
	input  wire logic        ev_runt,
	input  wire logic        ev_crc_bad,
	input  wire logic        ev_dribble,
	input  wire logic        ev_phy_err,
	input  wire logic        ev_frame_type,
	input  wire logic        ev_filter_miss,
	// state
	output logic             busy,
	output logic [31:0]      desc_addr,
	// descriptor side
	rx_desc_if.device        dsc
);
	walk_state_t state_q;
	logic [31:0] ctrl_q;
	logic [31:0] first_q;
	logic [31:0] second_q;
	logic [31:0] addr_q;
	logic [31:0] next_q;
	logic        wrap;
	logic        chain;
	logic [10:0] first_bytes;
	logic [10:0] second_bytes;
	logic [31:0] next_addr;
	logic [31:0] status_q;
	logic        status_v_q;
	logic        buf_v_q;
	logic [31:0] buf_addr_q;
	logic [10:0] buf_bytes_q;
	logic        first_grant;
	logic        second_grant;
	logic        second_sent_q;
	logic        runt_masked;
	logic        short_runt;
	logic [31:0] status_d;

	assign wrap         = ctrl_q[`RING_WRAP_BIT];
	assign chain        = ctrl_q[`CHAIN_NEXT_BIT] & ~wrap;
	assign first_bytes  = ctrl_q[`FIRST_BYTES_HI:`FIRST_BYTES_LO];
	assign second_bytes = chain ? 11'h000 : ctrl_q[`SECOND_BYTES_HI:`SECOND_BYTES_LO];
	assign first_grant  = (state_q == WALK_FIRST) && (first_bytes != 11'h000);
	// the second buffer is granted once, and only while the frame still runs
	assign second_grant = (state_q == WALK_SECOND) && (second_bytes != 11'h000) && !frame_done
		&& !second_sent_q;

	always_comb begin
		if (wrap) begin
			next_addr = list_base;
		end else if (chain) begin
			next_addr = second_q;
		end else begin
			next_addr = addr_q + `DESC_STRIDE;
		end
	end

	assign busy           = (state_q != WALK_IDLE);
	assign desc_addr      = addr_q;
	assign dsc.fetch_req  = (state_q == WALK_FETCH);
	assign dsc.fetch_addr = addr_q;
	assign dsc.buf_valid  = buf_v_q;
	assign dsc.buf_addr   = buf_addr_q;
	assign dsc.buf_bytes  = buf_bytes_q;
	assign dsc.status_valid = status_v_q;
	assign dsc.status_word  = status_q;

	// walk sequencing
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_q <= WALK_IDLE;
		end else begin
			case (state_q)
				WALK_IDLE: begin
					if (start) begin
						state_q <= WALK_FETCH;
					end
				end
				WALK_FETCH: begin
					if (dsc.fetch_ack) begin
						state_q <= WALK_FIRST;
					end
				end
				WALK_FIRST: begin
					if (first_bytes != 11'h000 && frame_done) begin
						state_q <= WALK_STATUS;
					end else begin
						state_q <= WALK_SECOND;
					end
				end
				WALK_SECOND: begin
					if (second_bytes == 11'h000 || frame_done) begin
						state_q <= WALK_STATUS;
					end
				end
				WALK_STATUS: begin
					state_q <= WALK_FETCH;
				end
				default: begin
					state_q <= WALK_IDLE;
				end
			endcase
		end
	end

	// descriptor words held for the whole walk of one descriptor
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ctrl_q   <= 32'h0000_0000;
			first_q  <= 32'h0000_0000;
			second_q <= 32'h0000_0000;
		end else if (state_q == WALK_FETCH && dsc.fetch_ack) begin
			ctrl_q   <= dsc.control_word;
			first_q  <= dsc.first_pointer;
			second_q <= dsc.second_pointer;
		end
	end

	// current descriptor address and the one to fetch after it
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			addr_q <= 32'h0000_0000;
			next_q <= 32'h0000_0000;
		end else begin
			if (state_q == WALK_IDLE && start) begin
				addr_q <= list_base;
			end else if (state_q == WALK_STATUS) begin
				addr_q <= next_q;
			end
			if (state_q == WALK_FIRST) begin
				next_q <= next_addr;
			end
		end
	end

	// stops a second buffer being granted again while waiting for frame end
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			second_sent_q <= 1'b0;
		end else if (state_q != WALK_SECOND) begin
			second_sent_q <= 1'b0;
		end else if (second_grant) begin
			second_sent_q <= 1'b1;
		end
	end

	// buffer grant to the receive engine
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			buf_v_q     <= 1'b0;
			buf_addr_q  <= 32'h0000_0000;
			buf_bytes_q <= 11'h000;
		end else begin
			buf_v_q <= first_grant | second_grant;
			if (first_grant) begin
				buf_addr_q  <= first_q;
				buf_bytes_q <= first_bytes;
			end else if (second_grant) begin
				buf_addr_q  <= second_q;
				buf_bytes_q <= second_bytes;
			end
		end
	end

	// runt is only reported where no stronger completion kind applies
	assign runt_masked = ev_runt & ~ev_overrun & ~ev_watchdog & ~ev_collision;
	assign short_runt  = ev_runt && (frame_len < 14'(`RUNT_TYPE_BYTES));

	// completion status with validity masking
	always_comb begin
		status_d = 32'h0000_0000;
		status_d[`ST_OVERRUN_BIT]    = ev_overrun;
		status_d[`ST_CRC_BIT]        = ev_crc_bad | ev_phy_err;
		status_d[`ST_DRIBBLE_BIT]    = ev_dribble;
		status_d[`ST_PHY_FAULT_BIT]  = ev_phy_err;
		status_d[`ST_WATCHDOG_BIT]   = ev_watchdog;
		status_d[`ST_FRAME_TYPE_BIT] = ev_frame_type & ~short_runt;
		status_d[`ST_COLLISION_BIT]  = ev_collision & ~ev_overrun;
		status_d[`ST_RUNT_BIT]       = runt_masked;
		status_d[`ST_LEN_HI:`ST_LEN_LO] = ev_watchdog ? 14'h0000 : frame_len;
		status_d[`ST_FILTER_BIT]     = ev_filter_miss & ~short_runt;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			status_q   <= 32'h0000_0000;
			status_v_q <= 1'b0;
		end else begin
			status_v_q <= (state_q == WALK_STATUS);
			if (state_q == WALK_STATUS) begin
				status_q <= status_d;
			end
		end
	end
endmodule : rx_descriptor_walker

// *** hdl/rx_descriptor_host.sv ***
`timescale 1ns/1ps
`include "rx_desc_consts.svh"
module rx_descriptor_host
	import rx_desc_pkg::*;
(
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// descriptor contents supplied by the driver
	input  wire logic [31:0] drv_control,
	input  wire logic [31:0] drv_first,
	input  wire logic [31:0] drv_second,
	// status returned to the driver
	output logic             drv_status_valid,
	output logic [31:0]      drv_status,
	output logic [31:0]      drv_fetch_addr,
	// descriptor side
	rx_desc_if.host          dsc
);
	logic        ack_q;
	logic [31:0] ctrl_q;
	logic [31:0] first_q;
	logic [31:0] second_q;

	assign dsc.fetch_ack      = ack_q;
	assign dsc.control_word   = ctrl_q;
	assign dsc.first_pointer  = first_q;
	assign dsc.second_pointer = second_q;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ack_q    <= 1'b0;
			ctrl_q   <= 32'h0000_0000;
			first_q  <= 32'h0000_0000;
			second_q <= 32'h0000_0000;
		end else begin
			ack_q <= dsc.fetch_req & ~ack_q;
			if (dsc.fetch_req && !ack_q) begin
				// sizes rounded down to whole longwords
				ctrl_q <= {drv_control[31:22], drv_control[21:13], 2'b00,
					drv_control[10:2], 2'b00};
				first_q  <= {drv_first[31:2], 2'b00};
				second_q <= {drv_second[31:2], 2'b00};
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			drv_status_valid <= 1'b0;
			drv_status       <= 32'h0000_0000;
			drv_fetch_addr   <= 32'h0000_0000;
		end else begin
			drv_status_valid <= dsc.status_valid;
			if (dsc.status_valid) begin
				drv_status <= dsc.status_word;
			end
			if (dsc.fetch_req) begin
				drv_fetch_addr <= dsc.fetch_addr;
			end
		end
	end
endmodule : rx_descriptor_host

// *** verification/rx_descriptor_walker_checker.sv ***
`timescale 1ns/1ps
module rx_descriptor_walker_checker (
	// clock and reset
	input wire logic        ref_clk,
	input wire logic        rst,
	// descriptor fetch
	input wire logic        fetch_req,
	input wire logic        fetch_ack,
	input wire logic [31:0] control_word,
	input wire logic [31:0] first_pointer,
	input wire logic [31:0] second_pointer,
	// grants and status
	input wire logic        buf_valid,
	input wire logic [31:0] buf_addr,
	input wire logic [10:0] buf_bytes,
	input wire logic        status_valid,
	input wire logic [31:0] status_word
);
	logic [31:0] cw_q, p1_q, p2_q;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// words of the descriptor being walked
	always_ff @(posedge ref_clk) begin
		if (fetch_ack) begin
			cw_q <= control_word;
			p1_q <= first_pointer;
			p2_q <= second_pointer;
		end
	end
	a_req_held: assert property (fetch_req && !fetch_ack |=> fetch_req)
		else $error("fetch request dropped early");
	a_first_grant: assert property (
		buf_valid && !$past(buf_valid) && cw_q[10:0] != 11'h0
		|-> buf_addr == p1_q && buf_bytes == cw_q[10:0]) else $error("first grant wrong");
	a_second_grant: assert property (
		buf_valid && ($past(buf_valid) || cw_q[10:0] == 11'h0)
		|-> buf_addr == p2_q && buf_bytes == cw_q[21:11]) else $error("second grant wrong");
	a_chain_single: assert property (
		buf_valid && cw_q[24] && !cw_q[25] |=> !buf_valid) else $error("chained second grant");
	a_second_follows: assert property (
		buf_valid && !$past(buf_valid) && cw_q[10:0] != 11'h0 && cw_q[21:11] != 11'h0
		&& (cw_q[25] || !cw_q[24]) |=> buf_valid) else $error("second grant missing");
	a_ovf_flags: assert property (
		status_valid && status_word[0] |-> !status_word[11] && !status_word[6])
		else $error("overflow status flags wrong");
	a_wdog_flags: assert property (
		status_valid && status_word[4] |-> !status_word[11] && status_word[29:16] == 14'h0)
		else $error("watchdog status flags wrong");
	a_coll_runt: assert property (
		status_valid && status_word[6] |-> !status_word[11]) else $error("runt with collision");
	c_two_grants: cover property (buf_valid ##1 buf_valid);
	c_overflow: cover property (status_valid && status_word[0]);
	c_wrap_chain: cover property (fetch_ack && control_word[25] && control_word[24]);
endmodule : rx_descriptor_walker_checker

// *** verification/rx_descriptor_walker_tb_top.sv ***
`timescale 1ns/1ps
module rx_descriptor_walker_tb_top import rx_desc_pkg::*;;
	logic        ref_clk = 0, rst = 1, start = 0, frame_done = 0;
	logic [31:0] list_base = 32'h0000_1000, nxt = 32'h0000_1000, ctl = 0, p1 = 0, p2 = 0;
	logic [31:0] rs = 32'h0000_0034;
	logic [13:0] flen = 0;
	logic [8:0]  ev = 0;
	logic [42:0] exp_q[$], msk_q[$];
	int          num_errors = 0, check_count = 0;
	rx_desc_if   dsc();
	wire  [2:0]  seen = {dsc.status_valid, dsc.buf_valid, dsc.fetch_req};
	wire         busy;
	wire  [31:0] daddr;
	always #5 ref_clk = ~ref_clk;
	rx_descriptor_walker u_rx_descriptor_walker(.ref_clk, .rst, .start, .list_base, .frame_done,
		.frame_len(flen), .ev_overrun(ev[0]), .ev_watchdog(ev[4]), .ev_collision(ev[6]),
		.ev_runt(ev[7]), .ev_crc_bad(ev[1]), .ev_dribble(ev[2]), .ev_phy_err(ev[3]),
		.ev_frame_type(ev[5]), .ev_filter_miss(ev[8]), .busy, .desc_addr(daddr), .dsc);
	rx_descriptor_host u_rx_descriptor_host(.ref_clk, .rst, .drv_control(ctl), .drv_first(p1),
		.drv_second(p2), .drv_status_valid(), .drv_status(), .drv_fetch_addr(), .dsc);
	rx_descriptor_walker_checker u_rx_descriptor_walker_checker(.ref_clk, .rst,
		.fetch_req(dsc.fetch_req), .fetch_ack(dsc.fetch_ack), .control_word(dsc.control_word),
		.first_pointer(dsc.first_pointer), .second_pointer(dsc.second_pointer),
		.buf_valid(dsc.buf_valid), .buf_addr(dsc.buf_addr), .buf_bytes(dsc.buf_bytes),
		.status_valid(dsc.status_valid), .status_word(dsc.status_word));
	function automatic logic [31:0] rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction : rnd
	task automatic conclude();
		if (exp_q.size() != 0) num_errors++;
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : conclude
	task automatic chk(input logic [42:0] a, e, m);
		check_count++;
		if ((a & m) !== (e & m)) begin
			num_errors++;
			$display("ERROR t=%0t got %h exp %h", $time, a, e);
		end
	endtask : chk
	// steps at least one edge, then waits for the chosen output
	task automatic wt(input int w);
		int i;
		i = 0;
		do @(posedge ref_clk) #1; while (seen[w] !== 1'b1 && ++i < 50);
		if (i == 50) begin
			num_errors++;
			conclude();
		end
	endtask : wt
	task automatic desc(input logic [31:0] c, a, b);
		logic [31:0] r, s, m;
		int k;
		r = rnd();
		ctl = c;
		p1 = a;
		p2 = b;
		ev = r[8:0];
		flen = {8'h0, r[14:9]};
		k = 0;
		a[1:0] = 2'h0;
		b[1:0] = 2'h0;
		c[1:0] = 2'h0;
		c[12:11] = 2'h0;
		if (c[10:0] != 11'h0) begin
			exp_q.push_back({a, c[10:0]});
			msk_q.push_back('1);
			k++;
		end
		if ((!c[24] || c[25]) && c[21:11] != 11'h0) begin
			exp_q.push_back({b, c[21:11]});
			msk_q.push_back('1);
			k++;
		end
		s = {1'b0, ev[8], ev[4] ? 14'h0 : flen, 4'h0, ev[7] & ~(ev[0] | ev[4] | ev[6]), 4'h0,
			ev[6] & ~ev[0], ev[5:2], ev[1] | ev[3], ev[0]};
		m = 32'h7FFF_087F;
		if (ev[0] || ev[4]) m[2:1] = 2'h0;
		if (ev[7] && flen < 14'd14) m = m & 32'hBFFF_FFDF;
		exp_q.push_back({11'h0, s});
		msk_q.push_back({11'h0, m});
		wt(0);
		start = 0;
		chk({11'h0, dsc.fetch_addr}, {11'h0, nxt}, '1);
		chk({10'h0, busy, daddr}, {10'h0, 1'b1, nxt}, '1);
		nxt = c[25] ? list_base : c[24] ? b : nxt + 32'h10;
		repeat (k) wt(1);
		frame_done = 1;
		wt(2);
		frame_done = 0;
	endtask : desc
	// outputs are looked at mid-cycle, where they have settled
	always @(negedge ref_clk) begin
		if (dsc.buf_valid === 1'b1 || dsc.status_valid === 1'b1) begin
			if (exp_q.size() == 0) chk(43'h1, 43'h0, '1);
			else chk(dsc.buf_valid ? {dsc.buf_addr, dsc.buf_bytes} : {11'h0, dsc.status_word},
				exp_q.pop_front(), msk_q.pop_front());
		end
	end
	initial begin
		repeat (10) @(posedge ref_clk);
		#1 rst = 0;
		@(posedge ref_clk) #1 start = 1;
		desc(32'h0000_4000, rnd(), rnd());
		for (int j = 0; j < 14; j++) begin
			start = (j == 5);
			desc(rnd() & 32'h033F_FFFF | 32'h10, rnd(), rnd());
		end
		// let the monitor take the last status note
		repeat (2) @(posedge ref_clk);
		conclude();
	end
endmodule : rx_descriptor_walker_tb_top
